/* rtl/meter_cfg_regs.vh */
// Register offsets, field positions, reset values and command codes
`ifndef METER_CFG_REGS_VH
`define METER_CFG_REGS_VH

`define ADDR_CONFIG         5'h00
`define ADDR_I_DC_OFFSET    5'h01
`define ADDR_I_GAIN         5'h02
`define ADDR_V_DC_OFFSET    5'h03
`define ADDR_V_GAIN         5'h04
`define ADDR_CYCLE_LENGTH   5'h05
`define ADDR_PULSE_RATE     5'h06
`define ADDR_STATUS         5'h0f
`define ADDR_PAGE_SELECT    5'h1f
`define ADDR_P3_VDIP_INT    5'h06
`define ADDR_P3_VDIP_LVL    5'h07
`define ADDR_P3_IFLT_INT    5'h0a
`define ADDR_P3_IFLT_LVL    5'h0b
`define PAGE_THREE          6'h03

`define RST_CONFIG          24'h000001
`define RST_DC_OFFSET       24'h000000
`define RST_GAIN            24'h400000
`define RST_CYCLE_LENGTH    24'h000fa0
`define RST_PULSE_RATE      24'h800000
`define RST_STATUS          24'h000000
`define RST_PAGE3           24'h000000

`define CFG_PHASE_MSB       23
`define CFG_PHASE_LSB       17
`define CFG_IGAIN_BIT       16
`define CFG_OPEN_DRAIN_BIT  15
`define CFG_IRQ_PULSE_BIT   12
`define CFG_IRQ_POL_BIT     11
`define CFG_CPU_INV_BIT     4
`define CFG_DIV_MSB         3
`define CFG_DIV_LSB         0
`define CFG_WRITABLE_MASK   24'hff981f
`define STATUS_DONE_BIT     23

`define CMD_CAL_PREFIX      3'b110
`define CAL_OFFSET_DC       3'b001
`define CAL_GAIN_DC         3'b010
`define CAL_OFFSET_AC       3'b101
`define CAL_GAIN_AC         3'b110
`define CONVS_PER_CYCLE_MUL 11'd1024
`define PULSE_RATE_DIV      12'd2048

`endif

/* rtl/clock_divider.v */
// Divides the master clock by a four-bit factor, zero meaning sixteen
`timescale 1ns/1ps
`default_nettype none
module clock_divider (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [3:0] divide_by,
    output reg        tick
);
    reg [3:0] count_reg;
    // Zero wraps to fifteen, so the period is sixteen
    wire [3:0] last_count = divide_by - 4'h1;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 4'h0;
            tick      <= 1'b0;
        end else if (count_reg >= last_count) begin
            count_reg <= 4'h0;
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + 4'h1;
            tick      <= 1'b0;
        end
    end
endmodule // clock_divider
`default_nettype wire

/* rtl/energy_pulse_gen.v */
// Energy pulse generator, toggles at master clock times rate over 2048
`timescale 1ns/1ps
`default_nettype none
module energy_pulse_gen (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        enable,
    input  wire [23:0] rate,
    output reg         pulse
);
    reg  [34:0] acc_reg;
    wire [23:0] magnitude = rate[23] ? (~rate + 24'h000001) : rate;
    // Rate is a fraction with 23 bits, divided further by 2048
    wire [34:0] limit = 35'h400000000;
    wire [34:0] sum   = acc_reg + {11'h000, magnitude};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= 35'h000000000;
            pulse   <= 1'b0;
        end else if (enable) begin
            if (sum >= limit) begin
                acc_reg <= sum - limit;
                pulse   <= ~pulse;
            end else begin
                acc_reg <= sum;
            end
        end
    end
endmodule // energy_pulse_gen
`default_nettype wire

/* rtl/meter_config_calibration_regs.v */
// Configuration and calibration register bank of an energy meter
//
// Contract
// - Calibration command low five bits select which calibration runs.
// - Upper selector bits pick channels; lower three pick offset or gain.
// - Page 3 dip and fault registers decode at 6, 7, 10, 11.
// - Seven-bit signed phase field delays voltage channel; resets zero.
// - Config bit 16 selects current gain 10 or 50.
// - Drive bit makes first two energy pins pull-down only.
// - Two interrupt style bits choose level or pulse and polarity.
// - Clock invert bit inverts the processor clock output.
// - Internal clock is master over four-bit divider; zero means 16.
// - DC offsets reset zero; DC offset calibration overwrites them, sets done.
// - DC offsets are 24-bit signed fractions.
// - Gains reset 1.0; gain calibration overwrites them, sets done.
// - Gains are unsigned with two integer bits.
// - Cycle length N resets 4000; cycles last 1024 times N.
// - Pulse outputs toggle at clock times rate over 2048.
// - Negative pulse rate behaves like its magnitude.
// - Done flag marks calibration end and each computation cycle.
// - Writing one clears a status bit; zero leaves it.
// - Register writes take effect only after all 24 data bits.
`timescale 1ns/1ps
`default_nettype none
`include "meter_cfg_regs.vh"
module meter_config_calibration_regs (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_byte,
    input  wire        wr_data_valid,
    input  wire [23:0] wr_data,
    output reg  [23:0] rd_data,
    output reg         rd_valid,
    input  wire        run_continuous,
    input  wire        meas_valid,
    input  wire [23:0] meas_i_offset,
    input  wire [23:0] meas_v_offset,
    input  wire [23:0] meas_i_gain,
    input  wire [23:0] meas_v_gain,
    input  wire        irq_event,
    input  wire        energy_sense,
    output wire [6:0]  phase_comp_delay,
    output wire        current_gain_50,
    output wire        irq_out,
    output wire        processor_clock_out,
    output wire        divided_internal_clock,
    output wire        energy_pulse_one_out,
    output wire        energy_pulse_one_oe,
    output wire        energy_pulse_two_out,
    output wire        energy_pulse_two_oe,
    output wire        energy_pulse_three,
    output wire        cycle_done_flag,
    output reg         calibration_busy
);
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_CAL  = 2'd2;

    reg [23:0] config_reg;
    reg [23:0] i_offset_reg;
    reg [23:0] i_gain_reg;
    reg [23:0] v_offset_reg;
    reg [23:0] v_gain_reg;
    reg [23:0] cycle_length_reg;
    reg [23:0] pulse_rate_reg;
    reg [23:0] status_reg;
    reg [5:0]  page_reg;
    reg [23:0] vdip_int_reg;
    reg [23:0] vdip_lvl_reg;
    reg [23:0] iflt_int_reg;
    reg [23:0] iflt_lvl_reg;
    reg [1:0]  state_reg;
    reg        wr_pending_reg;
    reg [4:0]  wr_addr_reg;
    reg [4:0]  cal_sel_reg;
    reg [33:0] cycle_count_reg;
    reg [1:0]  irq_sync_reg;
    reg        irq_prev_reg;
    reg        irq_pulse_reg;
    reg        cpu_clk_reg;

    wire       div_tick;
    wire       cal_cmd;
    wire       rw_cmd;
    wire       is_write;
    wire [4:0] cmd_addr;
    wire       page3;
    wire       cycle_end;
    wire       cal_done;
    wire       set_done;
    wire       irq_level;
    wire       irq_rise;
    wire [33:0] cycle_limit;
    wire       e_pulse;

    assign cal_cmd  = cmd_valid && (cmd_byte[7:5] == `CMD_CAL_PREFIX);
    assign rw_cmd   = cmd_valid && !cmd_byte[7] && !cmd_byte[0];
    assign is_write = cmd_byte[6];
    assign cmd_addr = cmd_byte[5:1];
    assign page3    = (page_reg == `PAGE_THREE);

    // Config fields drive the block outputs
    // Phase field out
    assign phase_comp_delay = config_reg[`CFG_PHASE_MSB:`CFG_PHASE_LSB];
    assign current_gain_50  = config_reg[`CFG_IGAIN_BIT];

    clock_divider u_div (
        .clk       (clk),
        .rst_n     (rst_n),
        .divide_by (config_reg[`CFG_DIV_MSB:`CFG_DIV_LSB]),
        .tick      (div_tick)
    );
    assign divided_internal_clock = div_tick;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clk_reg <= 1'b0;
        end else if (div_tick) begin
            cpu_clk_reg <= ~cpu_clk_reg;
        end
    end
    assign processor_clock_out = cpu_clk_reg ^ config_reg[`CFG_CPU_INV_BIT];

    // Pulse generator from the rate register
    energy_pulse_gen u_pulse (
        .clk    (clk),
        .rst_n  (rst_n),
        .enable (energy_sense),
        .rate   (pulse_rate_reg),
        .pulse  (e_pulse)
    );

    assign energy_pulse_one_out = config_reg[`CFG_OPEN_DRAIN_BIT] ?
                                  1'b0 : e_pulse;
    assign energy_pulse_one_oe  = config_reg[`CFG_OPEN_DRAIN_BIT] ?
                                  ~e_pulse : 1'b1;
    assign energy_pulse_two_out = energy_pulse_one_out;
    assign energy_pulse_two_oe  = energy_pulse_one_oe;
    assign energy_pulse_three   = e_pulse;

    // Computation cycle length in divided ticks
    assign cycle_limit = {10'h000, cycle_length_reg} *
                         {23'h000000, `CONVS_PER_CYCLE_MUL};
    assign cycle_end = run_continuous && div_tick &&
                       (cycle_count_reg + 34'h1 >= cycle_limit);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_count_reg <= 34'h0;
        end else if (!run_continuous || cycle_end) begin
            cycle_count_reg <= 34'h0;
        end else if (div_tick) begin
            cycle_count_reg <= cycle_count_reg + 34'h1;
        end
    end

    // Calibration sequencer: waits for a measurement over one cycle
    assign cal_done = (state_reg == ST_CAL) && meas_valid;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg        <= ST_IDLE;
            cal_sel_reg      <= 5'h00;
            calibration_busy <= 1'b0;
        end else begin
            case (state_reg)
            ST_IDLE: begin
                if (cal_cmd) begin
                    cal_sel_reg      <= cmd_byte[4:0];
                    state_reg        <= ST_CAL;
                    calibration_busy <= 1'b1;
                end
            end
            ST_CAL: begin
                if (meas_valid) begin
                    state_reg        <= ST_IDLE;
                    calibration_busy <= 1'b0;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
            end
            endcase
        end
    end

    assign set_done = cal_done || cycle_end;
    assign cycle_done_flag = status_reg[`STATUS_DONE_BIT];

    // Register writes; data arrives only after the full 24 bits
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pending_reg <= 1'b0;
            wr_addr_reg    <= 5'h00;
        end else if (rw_cmd && is_write) begin
            wr_pending_reg <= 1'b1;
            wr_addr_reg    <= cmd_addr;
        end else if (wr_data_valid) begin
            wr_pending_reg <= 1'b0;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg       <= `RST_CONFIG;
            i_offset_reg     <= `RST_DC_OFFSET;
            i_gain_reg       <= `RST_GAIN;
            v_offset_reg     <= `RST_DC_OFFSET;
            v_gain_reg       <= `RST_GAIN;
            cycle_length_reg <= `RST_CYCLE_LENGTH;
            pulse_rate_reg   <= `RST_PULSE_RATE;
            status_reg       <= `RST_STATUS;
            page_reg         <= 6'h00;
            vdip_int_reg     <= `RST_PAGE3;
            vdip_lvl_reg     <= `RST_PAGE3;
            iflt_int_reg     <= `RST_PAGE3;
            iflt_lvl_reg     <= `RST_PAGE3;
        end else begin
            if (wr_pending_reg && wr_data_valid) begin
                if (wr_addr_reg == `ADDR_PAGE_SELECT) begin
                    page_reg <= wr_data[5:0];
                end else if (page3) begin
                    if (wr_addr_reg == `ADDR_P3_VDIP_INT) begin
                        vdip_int_reg <= wr_data;
                    end else if (wr_addr_reg == `ADDR_P3_VDIP_LVL) begin
                        vdip_lvl_reg <= wr_data;
                    end else if (wr_addr_reg == `ADDR_P3_IFLT_INT) begin
                        iflt_int_reg <= wr_data;
                    end else if (wr_addr_reg == `ADDR_P3_IFLT_LVL) begin
                        iflt_lvl_reg <= wr_data;
                    end
                end else if (wr_addr_reg == `ADDR_CONFIG) begin
                    config_reg <= wr_data & `CFG_WRITABLE_MASK;
                end else if (wr_addr_reg == `ADDR_I_DC_OFFSET) begin
                    i_offset_reg <= wr_data;
                end else if (wr_addr_reg == `ADDR_I_GAIN) begin
                    i_gain_reg <= wr_data;
                end else if (wr_addr_reg == `ADDR_V_DC_OFFSET) begin
                    v_offset_reg <= wr_data;
                end else if (wr_addr_reg == `ADDR_V_GAIN) begin
                    v_gain_reg <= wr_data;
                end else if (wr_addr_reg == `ADDR_CYCLE_LENGTH) begin
                    cycle_length_reg <= wr_data;
                end else if (wr_addr_reg == `ADDR_PULSE_RATE) begin
                    pulse_rate_reg <= wr_data;
                end
            end
            // Write one to clear, set wins
            if (wr_pending_reg && wr_data_valid && !page3 &&
                wr_addr_reg == `ADDR_STATUS) begin
                status_reg <= status_reg & ~wr_data;
            end
            if (set_done) begin
                status_reg[`STATUS_DONE_BIT] <= 1'b1;
            end
            // Only the selected channel and type
            if (cal_done) begin
                if (cal_sel_reg[2:0] == `CAL_OFFSET_DC) begin
                    if (cal_sel_reg[3]) i_offset_reg <= meas_i_offset;
                    if (cal_sel_reg[4]) v_offset_reg <= meas_v_offset;
                end
                // Both DC and AC gain codes update gains
                if (cal_sel_reg[2:0] == `CAL_GAIN_DC ||
                    cal_sel_reg[2:0] == `CAL_GAIN_AC) begin
                    if (cal_sel_reg[3]) i_gain_reg <= meas_i_gain;
                    if (cal_sel_reg[4]) v_gain_reg <= meas_v_gain;
                end
            end
        end
    end

    // Reads answer the cycle after the read command
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= 24'h000000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rw_cmd && !is_write;
            if (rw_cmd && !is_write) begin
                if (cmd_addr == `ADDR_PAGE_SELECT) begin
                    rd_data <= {18'h00000, page_reg};
                end else if (page3) begin
                    if (cmd_addr == `ADDR_P3_VDIP_INT) rd_data <= vdip_int_reg;
                    else if (cmd_addr == `ADDR_P3_VDIP_LVL)
                        rd_data <= vdip_lvl_reg;
                    else if (cmd_addr == `ADDR_P3_IFLT_INT)
                        rd_data <= iflt_int_reg;
                    else if (cmd_addr == `ADDR_P3_IFLT_LVL)
                        rd_data <= iflt_lvl_reg;
                    else rd_data <= 24'h000000;
                end else if (cmd_addr == `ADDR_CONFIG) rd_data <= config_reg;
                else if (cmd_addr == `ADDR_I_DC_OFFSET)
                    rd_data <= i_offset_reg;
                else if (cmd_addr == `ADDR_I_GAIN) rd_data <= i_gain_reg;
                else if (cmd_addr == `ADDR_V_DC_OFFSET)
                    rd_data <= v_offset_reg;
                else if (cmd_addr == `ADDR_V_GAIN) rd_data <= v_gain_reg;
                else if (cmd_addr == `ADDR_CYCLE_LENGTH)
                    rd_data <= cycle_length_reg;
                else if (cmd_addr == `ADDR_PULSE_RATE)
                    rd_data <= pulse_rate_reg;
                else if (cmd_addr == `ADDR_STATUS) rd_data <= status_reg;
                else rd_data <= 24'h000000;
            end
        end
    end

    // Interrupt pin style; event comes from another domain
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_sync_reg  <= 2'b00;
            irq_prev_reg  <= 1'b0;
            irq_pulse_reg <= 1'b0;
        end else begin
            irq_sync_reg  <= {irq_sync_reg[0], irq_event};
            irq_prev_reg  <= irq_sync_reg[1];
            irq_pulse_reg <= irq_rise;
        end
    end
    assign irq_level = irq_sync_reg[1];
    assign irq_rise  = irq_sync_reg[1] && !irq_prev_reg;
    // Pulse styles idle at the opposite level of their edge
    assign irq_out = config_reg[`CFG_IRQ_PULSE_BIT] ?
                     (config_reg[`CFG_IRQ_POL_BIT] ? irq_pulse_reg
                                                   : ~irq_pulse_reg) :
                     (config_reg[`CFG_IRQ_POL_BIT] ? irq_level
                                                   : ~irq_level);
endmodule // meter_config_calibration_regs
`default_nettype wire

/* test/meter_config_calibration_regs_chk.sv */
// Port-level assertions for the calibration register bank
`timescale 1ns/1ps
`default_nettype none
module meter_regs_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_byte,
    input wire logic        wr_data_valid,
    input wire logic [23:0] wr_data,
    input wire logic        rd_valid,
    input wire logic        meas_valid,
    input wire logic [6:0]  phase_comp_delay,
    input wire logic        current_gain_50,
    input wire logic        divided_internal_clock,
    input wire logic        cycle_done_flag,
    input wire logic        calibration_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic rd_cmd = cmd_valid && cmd_byte[7:6] == 2'b00 && !cmd_byte[0];
    wire logic cal_cmd = cmd_valid && cmd_byte[7:5] == 3'b110;

    property p_rd_answer;
        rd_cmd |=> rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read command got no answer");
    property p_rd_cause;
        rd_valid |-> $past(rd_cmd);
    endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("read answer without a read command");
    property p_cal_start;
        cal_cmd && !calibration_busy |=> calibration_busy;
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("calibration command did not start");
    property p_busy_cause;
        $rose(calibration_busy) |-> $past(cal_cmd);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("calibration began without a command");
    property p_cal_end;
        calibration_busy && meas_valid |=>
            !calibration_busy && cycle_done_flag;
    endproperty
    a_cal_end: assert property (p_cal_end)
        else $error("calibration end not flagged");
    property p_done_hold;
        $fell(cycle_done_flag) |-> $past(wr_data_valid && wr_data[23]);
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done flag dropped without a clearing write");
    property p_cfg_cause;
        !$stable({phase_comp_delay, current_gain_50}) |-> $past(wr_data_valid);
    endproperty
    a_cfg_cause: assert property (p_cfg_cause)
        else $error("config outputs moved without a write");
    property p_div_tick;
        divided_internal_clock |-> ##[1:16] divided_internal_clock;
    endproperty
    a_div_tick: assert property (p_div_tick)
        else $error("divided clock tick gap above sixteen");
endmodule // meter_regs_chk

bind meter_config_calibration_regs meter_regs_chk u_chk (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .wr_data_valid(wr_data_valid), .wr_data(wr_data), .rd_valid(rd_valid),
    .meas_valid(meas_valid), .phase_comp_delay(phase_comp_delay),
    .current_gain_50(current_gain_50),
    .divided_internal_clock(divided_internal_clock),
    .cycle_done_flag(cycle_done_flag), .calibration_busy(calibration_busy)
);
`default_nettype wire

/* test/meter_host_model.sv */
// Host processor model issuing register and calibration commands
`timescale 1ns/1ps
`default_nettype none
`include "meter_cfg_regs.vh"
module meter_host_model (
    input  wire logic   clk,
    output logic        cmd_valid,
    output logic [7:0]  cmd_byte,
    output logic        wr_data_valid,
    output logic [23:0] wr_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'hff;
        wr_data_valid = 1'b0;
        wr_data = 24'h0;
    end
    task automatic send(input logic [7:0] c);
        @(negedge clk);
        cmd_valid <= 1'b1;
        cmd_byte <= c;
        @(negedge clk);
        cmd_valid <= 1'b0;
        // Released byte never keeps its old value
        cmd_byte <= ~c;
    endtask
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        send({2'b01, a, 1'b0});
        wr_data_valid <= 1'b1;
        wr_data <= (a == `ADDR_CONFIG) ? d & `CFG_WRITABLE_MASK : d;
        @(negedge clk);
        wr_data_valid <= 1'b0;
        wr_data <= ~d;
        @(negedge clk);
    endtask
    // listed codes only, inputs already set
    task automatic cal(input logic [4:0] code);
        send({`CMD_CAL_PREFIX, code});
    endtask
endmodule // meter_host_model
`default_nettype wire

/* test/meter_config_calibration_regs_tb_top.sv */
// Self-checking bench for the calibration register bank
`timescale 1ns/1ps
`default_nettype none
`include "meter_cfg_regs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module meter_config_calibration_regs_tb_top;
    logic clk, rst_n, cmd_valid, wr_data_valid, rd_valid, meas_valid;
    logic irq_event, energy_sense, run_continuous, seen;
    logic [7:0] cmd_byte;
    logic [23:0] wr_data, rd_data, mi_off, mv_off, mi_gn, mv_gn, d, e_t, m_t;
    logic [6:0] phase;
    logic gain50, irq_out, pclk, tick, e1o, e1e, e2o, e2e, e3, done, busy, p;
    int failures, n_compared, cyc, n, bad;
    logic [31:0] seed = 32'h847f1cce;
    logic [23:0] exp_q[$], msk_q[$], regs[1:4], p3v[4];
    logic [23:0] rst_tab[7] = '{`RST_CONFIG, `RST_DC_OFFSET, `RST_GAIN,
        `RST_DC_OFFSET, `RST_GAIN, `RST_CYCLE_LENGTH, `RST_PULSE_RATE};
    logic [4:0] p3[4] = '{`ADDR_P3_VDIP_INT, `ADDR_P3_VDIP_LVL,
        `ADDR_P3_IFLT_INT, `ADDR_P3_IFLT_LVL};
    logic [4:0] cal[12] = '{5'h09, 5'h0a, 5'h0d, 5'h0e, 5'h11, 5'h12,
        5'h15, 5'h16, 5'h19, 5'h1a, 5'h1d, 5'h1e};
    logic [3:0] kv[3] = '{4'h0, 4'h1, 4'h5};
    logic [23:0] rates[2] = '{24'h400000, 24'hc00000};

    meter_config_calibration_regs u_meter_config_calibration_regs (
        .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .wr_data_valid(wr_data_valid), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .run_continuous(run_continuous),
        .meas_valid(meas_valid), .meas_i_offset(mi_off),
        .meas_v_offset(mv_off), .meas_i_gain(mi_gn), .meas_v_gain(mv_gn),
        .irq_event(irq_event), .energy_sense(energy_sense),
        .phase_comp_delay(phase), .current_gain_50(gain50),
        .irq_out(irq_out), .processor_clock_out(pclk),
        .divided_internal_clock(tick), .energy_pulse_one_out(e1o),
        .energy_pulse_one_oe(e1e), .energy_pulse_two_out(e2o),
        .energy_pulse_two_oe(e2e), .energy_pulse_three(e3),
        .cycle_done_flag(done), .calibration_busy(busy));
    meter_host_model u_meter_host_model (.clk(clk), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .wr_data_valid(wr_data_valid), .wr_data(wr_data));

    function automatic logic [23:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[23:0];
    endfunction
    task automatic rd(input logic [4:0] a, input logic [23:0] e,
                      input logic [23:0] m = 24'hffffff);
        exp_q.push_back(e);
        msk_q.push_back(m);
        u_meter_host_model.send({2'b00, a, 1'b0});
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Oldest expectation meets each read answer
    always @(negedge clk) if (rd_valid === 1'b1) begin
        e_t = exp_q.pop_front();
        m_t = msk_q.pop_front();
        `CHK("rd_data", e_t & m_t, rd_data & m_t)
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        {rst_n, meas_valid, irq_event, energy_sense, run_continuous} = 5'h0;
        {mi_off, mv_off, mi_gn, mv_gn} = 96'h0;
        repeat (20) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        for (int a = 0; a < 7; a++) rd(a[4:0], rst_tab[a]);
        rd(5'h10, 24'h0);
        d = rnd() & `CFG_WRITABLE_MASK;
        u_meter_host_model.wr(`ADDR_CONFIG, d);
        rd(`ADDR_CONFIG, d);
        `CHK("phase", d[23:17], phase)
        `CHK("gain50", d[16], gain50)
        u_meter_host_model.wr(`ADDR_PAGE_SELECT, 24'h000003);
        foreach (p3[i]) begin
            p3v[i] = rnd();
            u_meter_host_model.wr(p3[i], p3v[i]);
        end
        foreach (p3[i]) rd(p3[i], p3v[i]);
        u_meter_host_model.wr(`ADDR_PAGE_SELECT, 24'h000000);
        rd(`ADDR_PULSE_RATE, `RST_PULSE_RATE);
        regs = '{`RST_DC_OFFSET, `RST_GAIN, `RST_DC_OFFSET, `RST_GAIN};
        foreach (cal[i]) begin
            @(negedge clk);
            {mi_off, mv_off, mi_gn, mv_gn} = {rnd(), rnd(), rnd(), rnd()};
            u_meter_host_model.cal(cal[i]);
            repeat (3) @(negedge clk);
            meas_valid = 1'b1;
            @(negedge clk) meas_valid = 1'b0;
            if (cal[i][2:0] == `CAL_OFFSET_DC) begin
                if (cal[i][3]) regs[1] = mi_off;
                if (cal[i][4]) regs[3] = mv_off;
            end
            // Both gain codes end in 10, both offset codes in 01
            if (cal[i][1:0] == 2'b10) begin
                if (cal[i][3]) regs[2] = mi_gn;
                if (cal[i][4]) regs[4] = mv_gn;
            end
            rd(`ADDR_STATUS, 24'h800000, 24'h800000);
            u_meter_host_model.wr(`ADDR_STATUS, 24'h800000);
            rd(`ADDR_STATUS, 24'h0, 24'h800000);
            for (int a = 1; a < 5; a++) rd(a[4:0], regs[a]);
        end
        foreach (kv[i]) begin
            u_meter_host_model.wr(`ADDR_CONFIG, {20'h0, kv[i]});
            while (tick !== 1'b1) @(negedge clk);
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (tick !== 1'b1);
            `CHK("div", (kv[i] == 4'h0) ? 16 : int'(kv[i]), n)
        end
        u_meter_host_model.wr(`ADDR_CONFIG, 24'h000000);
        while (tick !== 1'b1) @(negedge clk);
        // The clock moves one edge after the tick, then rests 16 cycles
        @(negedge clk) p = pclk;
        u_meter_host_model.wr(`ADDR_CONFIG, 24'h000010);
        `CHK("cpu clock", ~p, pclk)
        u_meter_host_model.wr(`ADDR_CONFIG, 24'h008001);
        energy_sense = 1'b1;
        bad = 0;
        foreach (rates[i]) begin
            u_meter_host_model.wr(`ADDR_PULSE_RATE, rates[i]);
            p = e3;
            while (e3 === p) @(negedge clk);
            p = e3;
            n = 0;
            while (e3 === p) begin
                @(negedge clk);
                n++;
                if ((e1e && e1o) || (e2e && e2o)) bad++;
            end
            `CHK("period", 4096, n)
        end
        `CHK("open drain", 0, bad)
        u_meter_host_model.wr(`ADDR_CONFIG, 24'h000001);
        `CHK("drive", 2'b11, {e1e, e2e})
        energy_sense = 1'b0;
        for (int m = 0; m < 4; m++) begin
            u_meter_host_model.wr(`ADDR_CONFIG, {11'h0, m[1:0], 11'h001});
            repeat (4) @(negedge clk);
            `CHK("irq idle", ~m[0], irq_out)
            irq_event = 1'b1;
            seen = 1'b0;
            repeat (6) begin
                @(negedge clk);
                if (irq_out === m[0]) seen = 1'b1;
            end
            `CHK("irq active", 1'b1, seen)
            irq_event = 1'b0;
            repeat (8) @(negedge clk);
        end
        // Divider is one here, so a cycle of N = 1 lasts 1024 clocks
        u_meter_host_model.wr(`ADDR_CYCLE_LENGTH, 24'h000001);
        run_continuous = 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        `CHK("cycle", 1024, n)
        run_continuous = 1'b0;
        repeat (4) @(negedge clk);
        tally_and_finish();
    end
endmodule // meter_config_calibration_regs_tb_top
`default_nettype wire
